// >>> rtl/atspc_adc_ctrl.sv
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - trigger select 1, source 0: after run set, wait for pin edge.
// - pin edge type chosen by two edge-select bits starts conversion.
// - external trigger: after conversion, wait for next pin edge.
// - pin edge during conversion restarts conversion from the start.
// - hardware trigger: control write during conversion aborts, back to waiting.
// - trigger select 1, source 1: after run set, timer event starts conversion.
// - timer trigger: after each conversion, idle until next timer event.
// - timer event during conversion restarts it from the beginning.
// - select mode converts channel field only, stores result, raises done.
// - software trigger: control write during conversion restarts immediately.
// - scan mode converts channel 0 up to field, store and done each.
// - scan with hardware trigger: one full sequence per trigger, then wait.
// - scan aborted by register write resumes at channel 0.
// - hardware trigger during scan restarts sequence at channel 0.
// - comparison disabled: done raised at every conversion end.
// - enabled, polarity 0: done only if upper 8 bits >= threshold.
// - enabled, polarity 1: done only if upper 8 bits < threshold.
// - comparison enabled: result always overwritten at conversion end.
// - comparison applies to every result, select and scan mode.
// - converter stops in standby; software should clear run first.
// - result in upper 10 of 16 bits, lower 6 zero; byte view upper 8.
// - trigger select 0: start on run set, repeat until run cleared.
// - 3-bit channel field: channel N select, 0 through N scan.
module atspc_adc_ctrl (
	input wire logic clock,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ext_start_pin,
	input wire logic timer_match_event,
	input wire logic standby,
	input wire logic [9:0] sar_data,
	output logic [2:0] analog_channel,
	output logic sample_start,
	output logic conversion_done_irq
);
	// ****************************************************************
	// bus slave
	// ****************************************************************
	atspc_pkg::atspc_req_t req;
	logic [7:0] conv_mode_reg;
	logic [7:0] channel_select_reg;
	logic [7:0] powerfail_mode_reg;
	logic [7:0] powerfail_threshold;
	logic [9:0] result;

	assign req.addr = wb_adr_i[atspc_pkg::ADDR_MSB:atspc_pkg::ADDR_LSB];
	assign req.data = wb_dat_i;
	assign req.sel = wb_sel_i;
	assign req.write = wb_we_i;

	wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wrLane0 = busReq && req.write && req.sel[0];
	wire wrMode = wrLane0 && (req.addr == atspc_pkg::ADDR_MODE);
	wire wrChan = wrLane0 && (req.addr == atspc_pkg::ADDR_CHAN);
	wire wrPfMode = wrLane0 && (req.addr == atspc_pkg::ADDR_PFMODE);
	wire wrPfThr = wrLane0 && (req.addr == atspc_pkg::ADDR_PFTHR);
	wire ctrlWrite = wrMode || wrChan || wrPfMode || wrPfThr;
	// a write that clears run must not leave a restart pulse behind
	wire runOff = wrMode && !req.data[atspc_pkg::MODE_RUN];

	// ****************************************************************
	// control decode
	// ****************************************************************
	wire convRun = conv_mode_reg[atspc_pkg::MODE_RUN];
	wire scanSelect = conv_mode_reg[atspc_pkg::MODE_SCAN];
	wire startSourceSelect = channel_select_reg[atspc_pkg::CHAN_TRG];
	wire hwStartSource = channel_select_reg[atspc_pkg::CHAN_HWSRC];
	wire [1:0] edgeSel = {channel_select_reg[atspc_pkg::CHAN_EDGE_HI],
		channel_select_reg[atspc_pkg::CHAN_EDGE_LO]};
	wire [2:0] chanField = channel_select_reg[atspc_pkg::CH_W-1:0];
	wire pfEnable = powerfail_mode_reg[atspc_pkg::PF_EN];
	wire pfPolarity = powerfail_mode_reg[atspc_pkg::PF_POL];

	// ****************************************************************
	// trigger pin: two-stage sync then edge compare
	// ****************************************************************
	logic pinMeta;
	logic pinSync;
	logic pinPrev;
	logic timerSync1;
	logic timerSync2;
	always_ff @(posedge clock) begin
		pinMeta <= ext_start_pin;
		pinSync <= pinMeta;
		pinPrev <= pinSync;
	end
	// timer event treated as same-clock pulse
	assign timerSync1 = timer_match_event;
	assign timerSync2 = timerSync1;

	function automatic logic edgeHit(input logic [1:0] sel, input logic cur, input logic prev);
		edgeHit = (sel == atspc_pkg::EDGE_RISE && cur && !prev) ||
			(sel == atspc_pkg::EDGE_FALL && !cur && prev) ||
			(sel == atspc_pkg::EDGE_BOTH && cur != prev);
	endfunction

	wire pinEdge = edgeHit(edgeSel, pinSync, pinPrev);
	wire hwTrigger = startSourceSelect &&
		(hwStartSource ? timerSync2 : pinEdge);

	// ****************************************************************
	// sequencer
	// ****************************************************************
	atspc_pkg::atspc_state_t state;
	atspc_pkg::atspc_state_t next_state;
	logic [7:0] convCount;
	logic [2:0] chan;
	logic [7:0] next_count;
	logic [2:0] next_chan;
	logic next_start;
	logic finish;

	wire active = convRun && !standby;
	wire convEnd = (state == atspc_pkg::ATSPC_CONV) &&
		(convCount == atspc_pkg::CONV_CYCLES) && !ctrlWrite;
	wire lastChan = !scanSelect || (chan == chanField);
	wire [7:0] resultHigh = result[atspc_pkg::RES_W-1:atspc_pkg::RES_W-8];
	wire [7:0] sarHigh = sar_data[atspc_pkg::RES_W-1:atspc_pkg::RES_W-8];
	wire pfPass = !pfEnable ||
		(pfPolarity ? (sarHigh < powerfail_threshold)
			: (sarHigh >= powerfail_threshold));

	always_comb begin
		next_state = state;
		next_count = convCount;
		next_chan = chan;
		next_start = 1'b0;
		finish = 1'b0;
		case (state)
			atspc_pkg::ATSPC_IDLE: begin
				if (active) begin
					next_chan = '0;
					if (startSourceSelect) begin
						next_state = atspc_pkg::ATSPC_WAIT;
					end else begin
						next_state = atspc_pkg::ATSPC_CONV;
						next_count = '0;
						next_start = 1'b1;
					end
				end
			end
			atspc_pkg::ATSPC_WAIT: begin
				if (hwTrigger) begin
					next_state = atspc_pkg::ATSPC_CONV;
					next_count = '0;
					next_chan = '0;
					next_start = 1'b1;
				end
			end
			atspc_pkg::ATSPC_CONV: begin
				if (ctrlWrite) begin
					next_chan = '0;
					next_count = '0;
					if (startSourceSelect) begin
						next_state = atspc_pkg::ATSPC_WAIT;
					end else begin
						next_start = 1'b1;
					end
				end else if (hwTrigger) begin
					next_chan = '0;
					next_count = '0;
					next_start = 1'b1;
				end else if (convEnd) begin
					finish = 1'b1;
					next_count = '0;
					if (!lastChan) begin
						next_chan = chan + 3'h1;
						next_start = 1'b1;
					end else if (startSourceSelect) begin
						next_chan = '0;
						next_state = atspc_pkg::ATSPC_WAIT;
					end else begin
						next_chan = '0;
						next_start = 1'b1;
					end
				end else begin
					next_count = convCount + 8'h01;
				end
			end
			default: next_state = atspc_pkg::ATSPC_IDLE;
		endcase
		if (!active || runOff) begin
			next_state = atspc_pkg::ATSPC_IDLE;
			next_start = 1'b0;
			finish = 1'b0;
		end
	end

	// restarts caused by a write steer the channel that the write just chose
	wire [7:0] modeFresh = wrMode ? req.data[7:0] : conv_mode_reg;
	wire [7:0] chanFresh = wrChan ? req.data[7:0] : channel_select_reg;
	wire [2:0] selChan = modeFresh[atspc_pkg::MODE_SCAN] ? next_chan
		: chanFresh[atspc_pkg::CH_W-1:0];

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= atspc_pkg::ATSPC_IDLE;
			convCount <= '0;
			chan <= '0;
			analog_channel <= '0;
			sample_start <= 1'b0;
			conversion_done_irq <= 1'b0;
			result <= '0;
		end else begin
			state <= next_state;
			convCount <= next_count;
			chan <= next_chan;
			analog_channel <= selChan;
			sample_start <= next_start;
			conversion_done_irq <= finish && pfPass;
			if (finish) begin
				result <= sar_data;
			end
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	logic [31:0] readData;
	always_comb begin
		readData = atspc_pkg::RESET_WORD;
		if (req.addr == atspc_pkg::ADDR_MODE) begin
			readData[7:0] = conv_mode_reg;
		end else if (req.addr == atspc_pkg::ADDR_CHAN) begin
			readData[7:0] = channel_select_reg;
		end else if (req.addr == atspc_pkg::ADDR_RESULT) begin
			readData[15:0] = {result, {atspc_pkg::RES_PAD{1'b0}}};
			readData[23:16] = resultHigh;
		end else if (req.addr == atspc_pkg::ADDR_PFMODE) begin
			readData[7:0] = powerfail_mode_reg;
		end else if (req.addr == atspc_pkg::ADDR_PFTHR) begin
			readData[7:0] = powerfail_threshold;
		end else if (req.addr == atspc_pkg::ADDR_STATUS) begin
			readData[2:0] = chan;
			readData[4] = (state == atspc_pkg::ATSPC_CONV);
			readData[5] = (state == atspc_pkg::ATSPC_WAIT);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			conv_mode_reg <= atspc_pkg::RESET_BYTE;
			channel_select_reg <= atspc_pkg::RESET_BYTE;
			powerfail_mode_reg <= atspc_pkg::RESET_BYTE;
			powerfail_threshold <= atspc_pkg::RESET_BYTE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= atspc_pkg::RESET_WORD;
		end else begin
			wb_ack_o <= busReq;
			wb_dat_o <= busReq ? readData : atspc_pkg::RESET_WORD;
			if (wrMode) begin
				conv_mode_reg <= req.data[7:0];
			end
			if (wrChan) begin
				channel_select_reg <= req.data[7:0];
			end
			if (wrPfMode) begin
				powerfail_mode_reg <= req.data[7:0];
			end
			if (wrPfThr) begin
				powerfail_threshold <= req.data[7:0];
			end
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_SW_RESTART: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && ctrlWrite && active && !startSourceSelect
			&& !runOff) |=> sample_start && state == atspc_pkg::ATSPC_CONV)
		else $error("software restart missing after control write");
	AST_HW_ABORT: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && ctrlWrite && active && startSourceSelect
			&& !runOff) |=> state == atspc_pkg::ATSPC_WAIT && !sample_start)
		else $error("hardware mode did not return to waiting");
	AST_TRIG_RESTART: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && hwTrigger && !ctrlWrite && active)
		|=> sample_start && chan == 3'h0 && convCount == 8'h00)
		else $error("trigger did not restart at channel 0");
	AST_WAIT_AFTER: assert property (@(posedge clock) disable iff (reset)
		(finish && lastChan && startSourceSelect) |=> state == atspc_pkg::ATSPC_WAIT)
		else $error("hardware mode kept converting");
	AST_PF_GE: assert property (@(posedge clock) disable iff (reset)
		(finish && pfEnable && !pfPolarity && sarHigh < powerfail_threshold)
		|=> !conversion_done_irq)
		else $error("done raised below threshold");
	AST_PF_LT: assert property (@(posedge clock) disable iff (reset)
		(finish && pfEnable && pfPolarity && sarHigh >= powerfail_threshold)
		|=> !conversion_done_irq)
		else $error("done raised at or above threshold");
	AST_PF_OFF: assert property (@(posedge clock) disable iff (reset)
		(finish && !pfEnable) |=> conversion_done_irq)
		else $error("done missing with comparison off");
	AST_RESULT: assert property (@(posedge clock) disable iff (reset)
		finish |=> result == $past(sar_data))
		else $error("result not overwritten");
	AST_SCAN_STEP: assert property (@(posedge clock) disable iff (reset)
		(finish && !lastChan) |=> chan == $past(chan) + 3'h1 && sample_start)
		else $error("scan did not advance channel");
	AST_STANDBY: assert property (@(posedge clock) disable iff (reset)
		standby |=> state == atspc_pkg::ATSPC_IDLE)
		else $error("converter running in standby");
	AST_ACK: assert property (@(posedge clock) disable iff (reset)
		busReq |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not one cycle");
	// trigger and sequencing checks; pin edges are judged on synchronised samples
	AST_SW_REPEAT: assert property (@(posedge clock) disable iff (reset)
		(finish && lastChan && !startSourceSelect)
		|=> sample_start && state == atspc_pkg::ATSPC_CONV)
		else $error("software mode did not convert again");
	AST_TIMER_IDLE: assert property (@(posedge clock) disable iff (reset)
		(finish && lastChan && startSourceSelect && hwStartSource) |=> !sample_start)
		else $error("timer mode converted again without an event");
	AST_SCAN_ONCE: assert property (@(posedge clock) disable iff (reset)
		(finish && scanSelect && lastChan && startSourceSelect)
		|=> state == atspc_pkg::ATSPC_WAIT && !sample_start)
		else $error("hardware scan did not stop after the last channel");
	AST_WAIT_QUIET: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_WAIT && !hwTrigger) |=> !sample_start)
		else $error("conversion started without a trigger");
	AST_EDGE_START: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_WAIT && active && !runOff && startSourceSelect
			&& !hwStartSource && pinEdge) |=> sample_start)
		else $error("selected pin edge did not start a conversion");
	AST_TIMER_START: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_WAIT && active && !runOff && startSourceSelect
			&& hwStartSource && timer_match_event) |=> sample_start)
		else $error("timer event did not start a conversion");
	AST_PIN_RESTART: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && active && !ctrlWrite && startSourceSelect
			&& !hwStartSource && pinEdge) |=> sample_start && convCount == 8'h00)
		else $error("pin edge did not restart the conversion");
	AST_TIMER_RESTART: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && active && !ctrlWrite && startSourceSelect
			&& hwStartSource && timer_match_event) |=> sample_start && convCount == 8'h00)
		else $error("timer event did not restart the conversion");
	AST_SCAN_ABORT: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_CONV && ctrlWrite && active) |=> chan == 3'h0)
		else $error("aborted scan did not return to channel 0");
	AST_SELECT_CHAN: assert property (@(posedge clock) disable iff (reset)
		(sample_start && !scanSelect) |-> analog_channel == chanField)
		else $error("select mode converted the wrong channel");
	AST_SCAN_CHAN: assert property (@(posedge clock) disable iff (reset)
		(sample_start && scanSelect) |-> analog_channel == chan)
		else $error("scan mode steered the wrong channel");
	// standby or a cleared run bit must silence both pulses
	AST_IDLE_QUIET: assert property (@(posedge clock) disable iff (reset)
		(state == atspc_pkg::ATSPC_IDLE) |-> !sample_start && !conversion_done_irq)
		else $error("idle converter produced activity");
	AST_PF_PASS: assert property (@(posedge clock) disable iff (reset)
		(finish && pfPass) |=> conversion_done_irq)
		else $error("done missing although the comparison passed");
	AST_RES_KEEP: assert property (@(posedge clock) disable iff (reset)
		!finish |=> result == $past(result))
		else $error("result changed without a conversion end");
	AST_RES_LAYOUT: assert property (@(posedge clock) disable iff (reset)
		(busReq && req.addr == atspc_pkg::ADDR_RESULT)
		|=> wb_dat_o[atspc_pkg::RES_PAD-1:0] == '0 && wb_dat_o[23:16] == wb_dat_o[15:8])
		else $error("result word layout wrong");
	AST_DATA_IDLE: assert property (@(posedge clock) disable iff (reset)
		!wb_ack_o |-> wb_dat_o == atspc_pkg::RESET_WORD)
		else $error("read data shown outside ack");
endmodule

// >>> shared/atspc_pkg.sv
package atspc_pkg;
	// ****************************************************************
	// register map (word addresses on the bus, byte offset = 4 * index)
	// ****************************************************************
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_CHAN = 4'h1;
	localparam logic [3:0] ADDR_RESULT = 4'h2;
	localparam logic [3:0] ADDR_PFMODE = 4'h3;
	localparam logic [3:0] ADDR_PFTHR = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 5;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int MODE_RUN = 7;
	localparam int MODE_SCAN = 6;
	localparam int MODE_STANDBY = 1;
	localparam int MODE_POWER = 0;
	localparam int CHAN_TRG = 7;
	localparam int CHAN_HWSRC = 6;
	localparam int CHAN_EDGE_HI = 5;
	localparam int CHAN_EDGE_LO = 4;
	localparam int PF_EN = 7;
	localparam int PF_POL = 6;
	localparam int RES_W = 10;
	localparam int RES_PAD = 6;
	localparam int CH_W = 3;

	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_NONE = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// time for one conversion, in clock cycles (plain default)
	localparam logic [7:0] CONV_CYCLES = 8'h18;

	typedef enum {ATSPC_IDLE, ATSPC_WAIT, ATSPC_CONV} atspc_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [31:0] data;
		logic [3:0] sel;
		logic write;
	} atspc_req_t;
endpackage

// >>> tb/adc_trigger_scan_powerfail_ctrl_tb.sv
`timescale 1ns/1ps
module adc_trigger_scan_powerfail_ctrl_tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, standby = 1'b0;
	logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd;
	logic [9:0] sar = 10'h000, s;
	logic [7:0] t;
	logic ack, irq, start, pin, tmr;
	logic [2:0] chan;
	logic [2:0] startCh[$];
	int error_cnt = 0, comparisons = 0, cycles = 0, irqCnt = 0, startCnt = 0;
	int expS[4] = '{1, 1, 0, 2};
	int expI[4] = '{1, 1, 0, 1};

	always #50 clock = ~clock;

	atspc_adc_ctrl u_dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(rd),
		.wb_ack_o(ack), .ext_start_pin(pin), .timer_match_event(tmr), .standby(standby),
		.sar_data(sar), .analog_channel(chan), .sample_start(start),
		.conversion_done_irq(irq));
	atspc_trig_src u_src (.clock(clock), .pinLevel(pin), .timerTick(tmr));

	// ****
	// monitors
	// ****
	// pulses last one cycle, so sample mid-cycle where they are settled
	always @(negedge clock) begin
		if (start === 1'b1) begin
			startCnt++;
			startCh.push_back(chan);
		end
		if (irq === 1'b1) irqCnt++;
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			close_out();
		end
	end

	// ****
	// tasks
	// ****
	task automatic close_out();
		$display("comparisons=%0d errors=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {26'h0, a, 2'h0};
		wdat <= {24'h0, d};
		// ack and data are read as sampled at the edge; only the bench timeout ends a hang
		do begin
			@(posedge clock);
		end while (ack !== 1'b1);
		rdat = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 8'h00);
		chk(rdat, exp);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic waitS(input int k);
		while (startCnt < k) begin
			@(posedge clock);
		end
	endtask
	task automatic clr();
		irqCnt = 0;
		startCnt = 0;
		startCh.delete();
	endtask
	function automatic logic [31:0] resWord(input logic [9:0] v);
		return {8'h00, v[9:2], v, 6'h00};
	endfunction
	function automatic logic pfHit(input logic en, input logic pol, input logic [9:0] v,
		input logic [7:0] th);
		return !en || (pol ? v[9:2] < th : v[9:2] >= th);
	endfunction

	// ****
	// sequence
	// ****
	initial begin
		void'($urandom(32'hCAE5));
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		foreach (expS[i]) rdchk(4'(i), 32'h0);
		rdchk(4'hF, 32'h0);
		$display("test reset done");
		sar <= 10'($urandom);
		wr(atspc_pkg::ADDR_CHAN, 8'h05);
		wr(atspc_pkg::ADDR_MODE, 8'h01);
		waitc(10);
		wr(atspc_pkg::ADDR_MODE, 8'h81);
		clr();
		waitc(70);
		chk(32'(irqCnt >= 2), 32'h1);
		chk(32'(startCh[0]), 32'h5);
		rdchk(atspc_pkg::ADDR_RESULT, resWord(sar));
		standby <= 1'b1;
		waitc(3);
		clr();
		waitc(60);
		chk(32'(startCnt + irqCnt), 32'h0);
		standby <= 1'b0;
		$display("test software select done");
		for (int i = 0; i < 8; i++) begin
			s = 10'($urandom);
			t = 8'($urandom);
			if (i < 2) t = s[9:2] + 8'(i);
			sar <= s;
			wr(atspc_pkg::ADDR_MODE, i < 4 ? 8'h81 : 8'hC1);
			wr(atspc_pkg::ADDR_PFMODE, {i < 6, i[0], 6'h00});
			wr(atspc_pkg::ADDR_PFTHR, t);
			clr();
			waitc(60);
			chk(32'(irqCnt != 0), 32'(pfHit(i < 6, i[0], s, t)));
			rdchk(atspc_pkg::ADDR_RESULT, resWord(s));
			rdchk(atspc_pkg::ADDR_PFTHR, {24'h0, t});
		end
		$display("test power fail done");
		wr(atspc_pkg::ADDR_CHAN, 8'h03);
		waitc(40);
		clr();
		wr(atspc_pkg::ADDR_PFTHR, 8'h00);
		waitS(4);
		foreach (expS[k]) chk(32'(startCh[k]), 32'(k));
		$display("test software scan done");
		wr(atspc_pkg::ADDR_CHAN, 8'h82);
		wr(atspc_pkg::ADDR_MODE, 8'h81);
		for (int e = 0; e < 4; e++) begin
			wr(atspc_pkg::ADDR_CHAN, {2'b10, 2'(e), 4'h2});
			clr();
			waitc(30);
			chk(32'(startCnt), 32'h0);
			u_src.pulse(10);
			waitc(80);
			chk(32'(startCnt), 32'(expS[e]));
			chk(32'(irqCnt), 32'(expI[e]));
		end
		$display("test external trigger done");
		wr(atspc_pkg::ADDR_CHAN, 8'hC1);
		clr();
		waitc(30);
		chk(32'(startCnt), 32'h0);
		u_src.tick();
		waitc(10);
		u_src.tick();
		waitc(80);
		chk(32'(startCnt), 32'h2);
		chk(32'(irqCnt), 32'h1);
		clr();
		u_src.tick();
		waitc(10);
		wr(atspc_pkg::ADDR_PFTHR, 8'h00);
		waitc(80);
		chk(32'(startCnt * 16 + irqCnt), 32'h10);
		rdchk(atspc_pkg::ADDR_STATUS, 32'h20);
		$display("test timer trigger done");
		wr(atspc_pkg::ADDR_MODE, 8'hC1);
		wr(atspc_pkg::ADDR_CHAN, 8'hC2);
		clr();
		u_src.tick();
		waitS(2);
		u_src.tick();
		waitc(150);
		chk(32'(startCnt), 32'h5);
		chk(32'(irqCnt), 32'h4);
		chk(32'(startCh[2]), 32'h0);
		chk(32'(startCh[4]), 32'h2);
		$display("test hardware scan done");
		close_out();
	end
endmodule

// >>> tb/atspc_trig_src.sv
`timescale 1ns/1ps
// ****
// far-side trigger sources
// ****
module atspc_trig_src (
	input wire logic clock,
	output logic pinLevel,
	output logic timerTick
);
	initial begin
		pinLevel = 1'b0;
		timerTick = 1'b0;
	end
	// timer match lasts one clock, same domain as the block
	task automatic tick();
		@(posedge clock);
		timerTick <= 1'b1;
		@(posedge clock);
		timerTick <= 1'b0;
	endtask
	// pin held long enough for the two-flop synchroniser to see both edges
	task automatic pulse(input int hiCycles);
		@(posedge clock);
		pinLevel <= 1'b1;
		repeat (hiCycles) @(posedge clock);
		pinLevel <= 1'b0;
	endtask
endmodule
